//--- common/ccs_pkg.sv
package ccs_pkg;

  ////////////////////////////////////////////////////////////////
  // timing
  localparam longint unsigned CLK_HZ     = 20_000_000;
  localparam longint unsigned T_LONG_S   = 1920;
  localparam longint unsigned T_SHORT_S  = 32;
  localparam longint unsigned T_RETRY_S  = 2;
  localparam longint unsigned T_PULSE_US = 128;
  localparam int              TW         = 36;
  localparam logic [TW-1:0]   LONG_CYC_DEF  = TW'(T_LONG_S * CLK_HZ);
  localparam logic [TW-1:0]   SHORT_CYC_DEF = TW'(T_SHORT_S * CLK_HZ);
  localparam logic [TW-1:0]   RETRY_CYC_DEF = TW'(T_RETRY_S * CLK_HZ);
  localparam logic [11:0]     PULSE_CYC     = 12'(T_PULSE_US * CLK_HZ / 1_000_000);
  localparam logic [1:0]      BOOT_WAIT     = 2'h3;

  ////////////////////////////////////////////////////////////////
  // register map
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_STAT  = 8'h04;
  localparam logic [7:0] A_PARAM = 8'h08;
  localparam int B_INH    = 0;
  localparam int B_HZ     = 1;
  localparam int B_TERM   = 2;
  localparam int B_STATEN = 3;
  localparam int B_PRST   = 4;
  localparam int B_WDR    = 5;
  localparam int B_ILDIS  = 6;
  localparam int B_IL500  = 7;
  localparam int P_VREG   = 0;
  localparam int P_ICHG   = 8;
  localparam int S_LAT    = 0;
  localparam int S_MODE   = 1;
  localparam int S_PH     = 2;
  localparam int S_FLD    = 5;
  localparam logic [5:0] VREG_DEF = 6'h02;
  localparam logic [3:0] ICHG_DEF = 4'h0;

  ////////////////////////////////////////////////////////////////
  // fault codes and flag positions
  localparam logic [2:0] FC_NONE = 3'h0;
  localparam logic [2:0] FC_OVP  = 3'h1;
  localparam logic [2:0] FC_SLP  = 3'h2;
  localparam logic [2:0] FC_POOR = 3'h3;
  localparam logic [2:0] FC_HOT  = 3'h4;
  localparam logic [2:0] FC_TMR  = 3'h5;
  localparam int F_SHORT = 0;
  localparam int F_WEAK  = 1;
  localparam int F_RCH   = 2;
  localparam int F_REG   = 3;
  localparam int F_TAPER = 4;
  localparam int F_SLEEP = 5;
  localparam int F_POOR  = 6;
  localparam int F_OVP   = 7;
  localparam int F_HOT   = 8;
  localparam int F_ILIM  = 9;
  localparam int F_STRAP = 10;
  localparam int NF      = 11;

  typedef enum logic [2:0] {
    PH_IDLE  = 3'b000,
    PH_SHORT = 3'b001,
    PH_FAST  = 3'b010,
    PH_REG   = 3'b011,
    PH_DONE  = 3'b100,
    PH_WAIT  = 3'b101,
    PH_FAULT = 3'b110
  } ccs_ph_e;

endpackage

//--- logic/ccs_sequencer.sv
// Operation
// - charge mode and high-impedance standby only
// - below short threshold use short current
// - fast charge, input limit defaults 100 mA
// - end charge on taper above recharge level
// - termination disabled when enable bit clear
// - restart on recharge, weak POR, inhibit/reset
// - long timer starts with charge, write stops
// - stopped long timer starts short host timer
// - restart bit restarts short timer, self-clears
// - short expiry restores defaults, long mode
// - long expiry: off, fault code, pulse
// - timer fault cleared only by POR
// - fault field updates only after read
// - POR with good battery keeps settings
// - weak battery long mode: defaults, strap limit
// - weak battery short mode keeps settings
// - defaults: no termination, 3.54 V regulation
// - input limit disable ignores loop request
// - thermal trip suspends charge, freezes timers
// - sleep turns off switch and PWM
// - poor source ends charge, waits, retries
// - input overvoltage stops PWM, flags fault
// - poor source retry after 2 seconds
// - status pin low charging, pulse on fault
// - inhibit bit 0 enables, 1 disables
// - parameter reset restores defaults, self-clears
`timescale 1ns/100ps
module ccs_sequencer
  import ccs_pkg::*;
#(
  parameter logic [TW-1:0] LONG_CYC  = LONG_CYC_DEF,
  parameter logic [TW-1:0] SHORT_CYC = SHORT_CYC_DEF,
  parameter logic [TW-1:0] RETRY_CYC = RETRY_CYC_DEF
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output wire logic        hreadyout,
  output wire logic        hresp,
  output wire logic [31:0] hrdata,
  input  wire logic        batt_short,
  input  wire logic        batt_weak,
  input  wire logic        batt_below_rch,
  input  wire logic        batt_at_reg,
  input  wire logic        taper_flag,
  input  wire logic        in_sleep,
  input  wire logic        in_poor,
  input  wire logic        in_ovp,
  input  wire logic        die_hot,
  input  wire logic        ilim_req,
  input  wire logic        input_limit_strap_pin,
  output wire logic        charge_en,
  output wire logic        pwm_en,
  output wire logic        block_sw_en,
  output wire logic        short_sel,
  output wire logic        ilim_500,
  output wire logic        ilim_active,
  output wire logic [5:0]  vreg_code,
  output wire logic [3:0]  ichg_code,
  output wire logic        stat_o,
  output wire logic        stat_oe
);

  ////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [NF-1:0] sa;
    logic [NF-1:0] sb;
    logic [1:0]    boot;
    ccs_ph_e       ph;
    logic          inh;
    logic          hz;
    logic          term_en;
    logic          stat_en;
    logic          prst;
    logic          wdr;
    logic          ildis;
    logic          il500;
    logic [5:0]    vreg;
    logic [3:0]    ichg;
    logic          lmode;
    logic [TW-1:0] tm;
    logic [TW-1:0] rt;
    logic [11:0]   pc;
    logic          flat;
    logic [2:0]    fld;
    logic          rd_ok;
    logic [2:0]    fprev;
    logic          a_wr;
    logic [7:0]    a_adr;
    logic          chg;
    logic          pwm;
    logic          sw;
    logic          shrt;
    logic          ilo;
    logic          ilact;
    logic          soe;
    logic          slo;
    logic          rdy;
    logic          rsp;
    logic [31:0]   rdat;
  } ccs_st_s;

  ccs_st_s       q;
  ccs_st_s       d;
  logic [NF-1:0] f;
  logic          acc;
  logic          booted;
  logic          ok;
  logic          rs;
  logic          chgph;
  logic [2:0]    want;

  ////////////////////////////////////////////////////////////////
  // helpers

  // charge parameters back to power-up values
  function automatic ccs_st_s dflt(input ccs_st_s s);
    ccs_st_s r;
    r = s;
    r.inh = 1'b0;
    r.hz = 1'b0;
    r.term_en = 1'b0;
    r.stat_en = 1'b1;
    r.ildis = 1'b0;
    r.il500 = 1'b0;
    r.vreg = VREG_DEF;
    r.ichg = ICHG_DEF;
    return r;
  endfunction

  function automatic ccs_ph_e pick(input logic [NF-1:0] fl);
    ccs_ph_e p;
    if (fl[F_SHORT]) begin
      p = PH_SHORT;
    end else if (!fl[F_REG]) begin
      p = PH_FAST;
    end else begin
      p = PH_REG;
    end
    return p;
  endfunction

  function automatic logic [31:0] rmux(input ccs_st_s s, input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      A_CTRL: begin
        v[B_INH] = s.inh;
        v[B_HZ] = s.hz;
        v[B_TERM] = s.term_en;
        v[B_STATEN] = s.stat_en;
        v[B_PRST] = s.prst;
        v[B_WDR] = s.wdr;
        v[B_ILDIS] = s.ildis;
        v[B_IL500] = s.il500;
      end
      A_STAT: begin
        v[S_LAT] = s.flat;
        v[S_MODE] = s.lmode;
        v[S_PH +: 3] = s.ph;
        v[S_FLD +: 3] = s.fld;
      end
      A_PARAM: begin
        v[P_VREG +: 6] = s.vreg;
        v[P_ICHG +: 4] = s.ichg;
      end
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    d = q;
    rs = 1'b0;
    // only the second stage is read by logic
    d.sa = {input_limit_strap_pin, ilim_req, die_hot, in_ovp, in_poor, in_sleep,
            taper_flag, batt_at_reg, batt_below_rch, batt_weak, batt_short};
    d.sb = q.sa;
    f = q.sb;
    booted = (q.boot == BOOT_WAIT);

    // bus: zero wait state, reads answered from the address phase
    acc = hsel & htrans[1] & hready;
    d.a_wr = acc & hwrite;
    d.a_adr = haddr[7:0];
    if (acc & !hwrite) begin
      d.rdat = rmux(q, haddr[7:0]);
      if (haddr[7:0] == A_STAT) begin
        d.rd_ok = 1'b1;
      end
    end

    // self-clearing bits drop once their effect has been applied
    d.wdr = 1'b0;
    if (q.prst) begin
      d = dflt(d);
      d.prst = 1'b0;
      rs = 1'b1;
    end

    // any host write hands the timer to the short watchdog
    if (q.a_wr) begin
      d.lmode = 1'b0;
      d.tm = '0;
      if (q.a_adr == A_CTRL) begin
        if (hwdata[B_INH] != q.inh) begin
          rs = 1'b1;
        end
        d.inh = hwdata[B_INH];
        d.hz = hwdata[B_HZ];
        d.term_en = hwdata[B_TERM];
        d.stat_en = hwdata[B_STATEN];
        d.prst = hwdata[B_PRST];
        d.wdr = hwdata[B_WDR];
        d.ildis = hwdata[B_ILDIS];
        d.il500 = hwdata[B_IL500];
      end else if (q.a_adr == A_PARAM) begin
        d.vreg = hwdata[P_VREG +: 6];
        d.ichg = hwdata[P_ICHG +: 4];
      end
    end

    // power-up: decide once the synchroniser holds settled values
    if (!booted) begin
      d.boot = q.boot + 2'h1;
      if (q.boot == BOOT_WAIT - 2'h1) begin
        rs = rs | f[F_WEAK];
        if (f[F_WEAK] & q.lmode) begin
          d = dflt(d);
          d.il500 = f[F_STRAP];
        end
        // otherwise the control registers stand as written
      end
    end

    ok = booted & !d.inh & !d.hz;

    // charge phase sequencing
    case (q.ph)
      PH_IDLE: begin
        if (ok) begin
          d.ph = pick(f);
          if (q.lmode) begin
            d.tm = '0;
          end
        end
      end
      PH_SHORT, PH_FAST, PH_REG: begin
        d.ph = pick(f);
        if (q.ph == PH_REG && f[F_TAPER] && !f[F_RCH] && q.term_en) begin
          d.ph = PH_DONE;
        end
        if (f[F_POOR]) begin
          d.ph = PH_WAIT;
          d.rt = '0;
        end
      end
      PH_DONE: begin
        if (f[F_RCH]) begin
          d.ph = pick(f);
        end
      end
      PH_WAIT: begin
        if (!f[F_HOT]) begin
          d.rt = q.rt + TW'(1);
        end
        if (q.rt >= RETRY_CYC - TW'(1)) begin
          d.ph = PH_IDLE;
        end
      end
      PH_FAULT: begin
        d.ph = PH_FAULT;
      end
      default: begin
        d.ph = PH_IDLE;
      end
    endcase

    chgph = (q.ph == PH_SHORT) | (q.ph == PH_FAST) | (q.ph == PH_REG);

    // safety timers, frozen while the die is over temperature
    if (booted && !f[F_HOT] && !q.a_wr && (chgph || !q.lmode)) begin
      d.tm = q.tm + TW'(1);
    end
    if (!q.lmode && q.tm >= SHORT_CYC - TW'(1)) begin
      d = dflt(d);
      d.lmode = 1'b1;
      d.tm = '0;
      rs = 1'b1;
    end
    if (q.lmode && chgph && q.tm >= LONG_CYC - TW'(1)) begin
      d.flat = 1'b1;
    end

    if (!ok && d.ph != PH_FAULT) begin
      d.ph = PH_IDLE;
    end
    if (rs) begin
      d.ph = PH_IDLE;
    end
    if (d.flat) begin
      d.ph = PH_FAULT;
    end

    // fault reporting
    if (d.flat) begin
      want = FC_TMR;
    end else if (f[F_HOT]) begin
      want = FC_HOT;
    end else if (f[F_OVP]) begin
      want = FC_OVP;
    end else if (d.ph == PH_WAIT) begin
      want = FC_POOR;
    end else if (f[F_SLEEP]) begin
      want = FC_SLP;
    end else begin
      want = FC_NONE;
    end
    d.fprev = want;
    if (q.pc != 12'h000) begin
      d.pc = q.pc - 12'h001;
    end
    if (want != q.fprev && want != FC_NONE) begin
      d.pc = PULSE_CYC;
    end
    // a read in this same cycle returned the old field, so the clear wins
    if (q.rd_ok && want != q.fld) begin
      d.fld = want;
      d.rd_ok = 1'b0;
    end

    // outputs
    chgph = (d.ph == PH_SHORT) | (d.ph == PH_FAST) | (d.ph == PH_REG);
    d.chg = chgph;
    d.pwm = chgph & !f[F_HOT] & !f[F_SLEEP] & !f[F_OVP];
    d.sw = booted & !d.hz & !f[F_SLEEP];
    d.shrt = (d.ph == PH_SHORT);
    d.ilo = d.il500;
    d.ilact = f[F_ILIM] & !d.ildis;
    d.soe = (chgph & d.stat_en) | (d.pc != 12'h000);
    d.slo = 1'b0;
    d.rdy = 1'b1;
    d.rsp = 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.stat_en <= 1'b1;
      q.vreg <= VREG_DEF;
      q.ichg <= ICHG_DEF;
      q.lmode <= 1'b1;
      q.rd_ok <= 1'b1;
      q.rdy <= 1'b1;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // ports

  assign hreadyout = q.rdy;
  assign hresp = q.rsp;
  assign hrdata = q.rdat;
  assign charge_en = q.chg;
  assign pwm_en = q.pwm;
  assign block_sw_en = q.sw;
  assign short_sel = q.shrt;
  assign ilim_500 = q.ilo;
  assign ilim_active = q.ilact;
  assign vreg_code = q.vreg;
  assign ichg_code = q.ichg;
  assign stat_o = q.slo;
  assign stat_oe = q.soe;

endmodule

//--- sim/ccs_host_model.sv
`timescale 1ns/100ps
module ccs_host_model (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  logic [31:0] rdata;
  event        got;

  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // single word transfer; a released data bus carries the inverse of its last value
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : ~hwdata;
    do @(posedge hclk); while (hready !== 1'b1);
    rdata = hrdata;
    hwdata <= ~hwdata;
    if (!w) ->got;
  endtask
endmodule

//--- sim/ccs_sequencer_sva.sv
`timescale 1ns/100ps
module ccs_sequencer_sva
  import ccs_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic stat_o,
  input wire logic stat_oe,
  input wire logic charge_en,
  input wire logic pwm_en,
  input wire logic block_sw_en,
  input wire logic in_sleep,
  input wire logic in_ovp,
  input wire logic die_hot,
  input wire logic ilim_req,
  input wire logic ilim_active
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // length of a status pulse seen while not charging
  logic [12:0] run_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_q <= 13'h0;
    end else if (stat_oe && !charge_en) begin
      run_q <= (run_q == 13'h1FFF) ? run_q : run_q + 13'h1;
    end else begin
      run_q <= 13'h0;
    end
  end

  ////////////////////////////////////////////////////////////////
  property p_bus; hreadyout && !hresp && !stat_o; endproperty
  property p_hot; die_hot [*4] |=> !pwm_en; endproperty
  property p_ovp; in_ovp [*4] |=> !pwm_en; endproperty
  property p_slp; in_sleep [*4] |=> !pwm_en && !block_sw_en; endproperty
  property p_ilim; !ilim_req [*4] |=> !ilim_active; endproperty
  property p_pwm; !charge_en [*2] |-> !pwm_en; endproperty
  property p_pulse; run_q <= 13'(PULSE_CYC) + 13'h4; endproperty
  property p_boot; $rose(hresetn) |-> (!charge_en) [*3]; endproperty

  a_bus: assert property (p_bus) else $error("bus answer or pin drive level wrong");
  a_hot: assert property (p_hot) else $error("pwm on while hot");
  a_ovp: assert property (p_ovp) else $error("pwm on during input overvoltage");
  a_slp: assert property (p_slp) else $error("switch or pwm on in sleep");
  a_ilim: assert property (p_ilim) else $error("limit loop active without request");
  a_pwm: assert property (p_pwm) else $error("pwm on while not charging");
  a_pulse: assert property (p_pulse) else $error("status pulse too long");
  a_boot: assert property (p_boot) else $error("charging before inputs synchronised");

  c_fault: cover property ($fell(charge_en) && stat_oe);
  c_ilim: cover property (ilim_active);
  c_hot: cover property (die_hot && charge_en && !pwm_en);
endmodule

bind ccs_sequencer ccs_sequencer_sva u_sva (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .stat_o(stat_o),
  .stat_oe(stat_oe), .charge_en(charge_en), .pwm_en(pwm_en), .block_sw_en(block_sw_en),
  .in_sleep(in_sleep), .in_ovp(in_ovp), .die_hot(die_hot), .ilim_req(ilim_req), .ilim_active(ilim_active)
);

//--- sim/charge_cycle_sequencer_tb.sv
`timescale 1ns/100ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin error_cnt++; $display("mismatch %0t got %h want %h", $time, a, e); end end
module charge_cycle_sequencer_tb
  import ccs_pkg::*;
;
  localparam int          LC  = 2000;
  localparam int          SC  = 200;
  localparam int          RC  = 50;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic             hclk, hresetn;
  logic [NF-1:0]    fl;
  logic [63:0]      q[$];
  logic [31:0]      d;
  int               error_cnt, samples_checked, cyc, seed;
  event             snap;
  wire logic        hsel, hwrite, hready, hresp, charge_en, pwm_en, block_sw_en;
  wire logic        short_sel, ilim_500, ilim_active, stat_o, stat_oe;
  wire logic [1:0]  htrans;
  wire logic [2:0]  hsize;
  wire logic [31:0] haddr, hwdata, hrdata;
  wire logic [5:0]  vreg_code;
  wire logic [3:0]  ichg_code;
  wire logic [31:0] pins = {15'h0, ichg_code, vreg_code, stat_oe, ilim_active, ilim_500,
                            short_sel, block_sw_en, pwm_en, charge_en};

  ccs_sequencer #(.LONG_CYC(TW'(LC)), .SHORT_CYC(TW'(SC)), .RETRY_CYC(TW'(RC))) DUT (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout(hready),
    .hresp, .hrdata, .batt_short(fl[F_SHORT]), .batt_weak(fl[F_WEAK]), .batt_below_rch(fl[F_RCH]),
    .batt_at_reg(fl[F_REG]), .taper_flag(fl[F_TAPER]), .in_sleep(fl[F_SLEEP]), .in_poor(fl[F_POOR]),
    .in_ovp(fl[F_OVP]), .die_hot(fl[F_HOT]), .ilim_req(fl[F_ILIM]), .input_limit_strap_pin(fl[F_STRAP]),
    .charge_en, .pwm_en, .block_sw_en, .short_sel, .ilim_500, .ilim_active, .vreg_code, .ichg_code,
    .stat_o, .stat_oe);
  ccs_host_model h (.hclk, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);

  ////////////////////////////////////////////////////////////////
  function automatic logic [NF-1:0] b(input int i);
    return NF'(1) << i;
  endfunction
  task automatic cmp(input logic [31:0] v);
    logic [63:0] n;
    n = q.pop_front();
    `CHK(v & n[63:32], n[31:0])
  endtask
  task automatic st;
    repeat (6) @(posedge hclk);
  endtask
  task automatic fs(input logic [NF-1:0] f);
    @(posedge hclk);
    fl <= f;
    st();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    q.push_back({m, e});
    h.xfer(1'b0, {24'h0, a}, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    h.xfer(1'b1, {24'h0, a}, v);
  endtask
  // pins are snapped just after the edge so register updates have landed
  task automatic pc(input logic [31:0] m, input logic [31:0] e);
    q.push_back({m, e});
    #1 ->snap;
  endtask
  task automatic rst(input logic [NF-1:0] f);
    @(posedge hclk);
    hresetn <= 1'b0;
    fl <= f;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (12) @(posedge hclk);
  endtask
  task automatic print_verdict;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(h.got) cmp(h.rdata);
  always @(snap) cmp(pins);
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 12000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    seed = 5009;
    hresetn = 1'b0;
    fl = '0;
    rst('0);
    rd(A_CTRL, ALL, 32'h08);
    rd(A_PARAM, ALL, {20'h0, ICHG_DEF, 2'h0, VREG_DEF});
    rd(A_STAT, ALL, 32'h0A);
    pc(32'h7F, 32'h47);
    repeat (LC - 100) @(posedge hclk);
    pc(32'h01, 32'h01);
    for (int n = 0; n < 200 && charge_en === 1'b1; n++) @(posedge hclk);
    st();
    pc(32'h41, 32'h40);
    rd(A_STAT, ALL, 32'hBB);
    repeat (2600) @(posedge hclk);
    pc(32'h41, 32'h00);
    wr(A_CTRL, 32'h08);
    rd(A_STAT, 32'h01, 32'h01);
    rst('0);
    rd(A_STAT, 32'h01, 32'h00);
    fs(b(F_OVP));
    pc(32'h03, 32'h01);
    rd(A_STAT, 32'hE0, 32'h20);
    fs(b(F_HOT));
    pc(32'h02, 32'h00);
    fs(b(F_OVP));
    rd(A_STAT, 32'hE0, 32'h80);
    rd(A_STAT, 32'hE0, 32'h20);
    fs('0);
    pc(32'h03, 32'h03);
    fs(b(F_SLEEP));
    pc(32'h06, 32'h00);
    fs(b(F_SHORT));
    pc(32'h08, 32'h08);
    rd(A_STAT, 32'h1C, 32'h04);
    fs('0);
    d = $random(seed) & 32'hF3F;
    wr(A_PARAM, d);
    rd(A_PARAM, ALL, d);
    pc(32'h1FF80, {15'h0, d[11:8], d[5:0], 7'h0});
    wr(A_CTRL, 32'h0C);
    fs(b(F_REG));
    rd(A_STAT, 32'h1C, 32'h0C);
    fs(b(F_REG) | b(F_TAPER));
    pc(32'h01, 32'h00);
    rd(A_STAT, 32'h1C, 32'h10);
    fs(b(F_RCH));
    pc(32'h01, 32'h01);
    wr(A_CTRL, 32'h08);
    fs(b(F_REG) | b(F_TAPER));
    pc(32'h01, 32'h01);
    fs('0);
    wr(A_CTRL, 32'h09);
    st();
    pc(32'h01, 32'h00);
    wr(A_CTRL, 32'h08);
    st();
    pc(32'h01, 32'h01);
    wr(A_CTRL, 32'h0A);
    st();
    pc(32'h05, 32'h00);
    fs(b(F_ILIM));
    wr(A_CTRL, 32'h88);
    st();
    pc(32'h30, 32'h30);
    wr(A_CTRL, 32'hC8);
    st();
    pc(32'h30, 32'h10);
    fs('0);
    wr(A_CTRL, 32'h28);
    rd(A_CTRL, ALL, 32'h08);
    wr(A_CTRL, 32'h18);
    rd(A_PARAM, ALL, 32'h02);
    rd(A_CTRL, ALL, 32'h08);
    rd(8'h0C, ALL, 32'h00);
    wr(A_PARAM, 32'h125);
    rd(A_STAT, 32'h02, 32'h00);
    repeat (SC + 100) @(posedge hclk);
    rd(A_STAT, 32'h02, 32'h02);
    rd(A_PARAM, ALL, 32'h02);
    fs(b(F_POOR));
    pc(32'h01, 32'h00);
    fs('0);
    repeat (RC - 20) @(posedge hclk);
    pc(32'h01, 32'h00);
    repeat (25) @(posedge hclk);
    pc(32'h01, 32'h01);
    rst(b(F_WEAK) | b(F_STRAP));
    pc(32'h11, 32'h11);
    rd(A_PARAM, ALL, 32'h02);
    // no fault pulse pending here, so a cleared enable must leave the pin released
    wr(A_CTRL, 32'h00);
    st();
    pc(32'h41, 32'h01);
    print_verdict();
  end
endmodule
